// *** logic/flash_host.sv ***
/*
 * Host-side controller that drives a parallel flash through its pins:
 * one read or write cycle per user request, bus width select, reset and
 * deep power-down sequencing, ready/busy monitoring.
 * Assumes the flash pins are joined by the bench; enables are high to drive.
 */
`timescale 1ns/10ps
module flash_host #(
   parameter int RECOVERY_CYC = flash_host_pkg::RECOVERY_CYC
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic power_good,
   input wire logic powerdown_req,
   input wire logic req_valid,
   input wire flash_host_pkg::req_t req,
   output logic req_ready,
   output logic rsp_valid,
   output logic [2*flash_host_pkg::LANE_W-1:0] rsp_data,
   output logic flash_busy,
   output logic flash_active,
   output flash_host_pkg::addr_t addr_o,
   output logic half_word_select_address_oe,
   output logic [flash_host_pkg::LANE_W-1:0] low_data_lane_o,
   output logic [flash_host_pkg::LANE_W-1:0] high_data_lane_o,
   output logic low_data_lane_oe,
   output logic high_data_lane_oe,
   input wire logic [flash_host_pkg::LANE_W-1:0] low_data_lane_i,
   input wire logic [flash_host_pkg::LANE_W-1:0] high_data_lane_i,
   output logic chip_select_n,
   output logic output_gate_n,
   output logic write_strobe_n,
   output logic width_select,
   output logic reset_powerdown_n,
   input wire logic ready_busy_n
);
   localparam logic [flash_host_pkg::CNT_W-1:0] SETUP_M1 = flash_host_pkg::CNT_W'(flash_host_pkg::SETUP_CYC - 1);
   localparam logic [flash_host_pkg::CNT_W-1:0] STROBE_M1 = flash_host_pkg::CNT_W'(flash_host_pkg::STROBE_CYC - 1);
   localparam logic [flash_host_pkg::CNT_W-1:0] ACCESS_M1 = flash_host_pkg::CNT_W'(flash_host_pkg::ACCESS_CYC - 1);
   localparam logic [flash_host_pkg::CNT_W-1:0] HOLD_M1 = flash_host_pkg::CNT_W'(flash_host_pkg::HOLD_CYC - 1);
   localparam logic [flash_host_pkg::CNT_W-1:0] PDOWN_M1 = flash_host_pkg::CNT_W'(flash_host_pkg::POWERDOWN_CYC - 1);
   localparam logic [flash_host_pkg::CNT_W-1:0] RECOV_M1 = flash_host_pkg::CNT_W'(RECOVERY_CYC - 1);

   flash_host_pkg::state_t state_q;
   flash_host_pkg::req_t cur_q;
   logic [flash_host_pkg::CNT_W-1:0] cnt_q;
   logic [flash_host_pkg::LANE_W-1:0] low_s;
   logic [flash_host_pkg::LANE_W-1:0] high_s;
   logic rb_s;
   logic cnt_zero;

   assign cnt_zero = (cnt_q == '0);

   // Busy pin resets to its pulled-up idle level, so no false busy follows reset
   pin_sync #(
      .WIDTH(2 * flash_host_pkg::LANE_W + 1),
      .INIT({1'b1, {(2 * flash_host_pkg::LANE_W){1'b0}}})
   ) u_sync (
      .mclk(mclk),
      .nrst(nrst),
      .pin({ready_busy_n, high_data_lane_i, low_data_lane_i}),
      .level({rb_s, high_s, low_s})
   );

   // Sequencer: power-down, recovery, then one access per request
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         state_q <= flash_host_pkg::ST_PDOWN;
         cnt_q <= '0;
         cur_q <= '0;
      end
      else
      begin
         if (!cnt_zero)
         begin
            cnt_q <= cnt_q - 1'b1;
         end
         unique case (state_q)
            flash_host_pkg::ST_PDOWN:
            begin
               if (power_good && !powerdown_req && cnt_zero)
               begin
                  state_q <= flash_host_pkg::ST_RECOVER;
                  cnt_q <= RECOV_M1;
               end
            end
            flash_host_pkg::ST_RECOVER:
            begin
               if (!power_good || powerdown_req)
               begin
                  state_q <= flash_host_pkg::ST_PDOWN;
                  cnt_q <= PDOWN_M1;
               end
               else if (cnt_zero)
               begin
                  state_q <= flash_host_pkg::ST_IDLE;
               end
            end
            flash_host_pkg::ST_IDLE:
            begin
               if (!power_good || powerdown_req)
               begin
                  state_q <= flash_host_pkg::ST_PDOWN;
                  cnt_q <= PDOWN_M1;
               end
               else if (req_valid)
               begin
                  cur_q <= req;
                  state_q <= flash_host_pkg::ST_SETUP;
                  cnt_q <= SETUP_M1;
               end
            end
            flash_host_pkg::ST_SETUP:
            begin
               if (cnt_zero)
               begin
                  state_q <= flash_host_pkg::ST_STROBE;
                  cnt_q <= cur_q.write ? STROBE_M1 : ACCESS_M1;
               end
            end
            flash_host_pkg::ST_STROBE:
            begin
               if (cnt_zero)
               begin
                  state_q <= flash_host_pkg::ST_HOLD;
                  cnt_q <= HOLD_M1;
               end
            end
            flash_host_pkg::ST_HOLD:
            begin
               if (cnt_zero)
               begin
                  state_q <= flash_host_pkg::ST_DONE;
               end
            end
            flash_host_pkg::ST_DONE:
            begin
               state_q <= flash_host_pkg::ST_IDLE;
            end
            default:
            begin
               state_q <= flash_host_pkg::ST_PDOWN;
            end
         endcase
      end
   end

   // Pin drive: address and data held from setup through hold
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         chip_select_n <= 1'b1;
         output_gate_n <= 1'b1;
         write_strobe_n <= 1'b1;
         reset_powerdown_n <= 1'b0;
         width_select <= 1'b0;
         addr_o <= '0;
         half_word_select_address_oe <= 1'b0;
         low_data_lane_o <= '0;
         high_data_lane_o <= '0;
         low_data_lane_oe <= 1'b0;
         high_data_lane_oe <= 1'b0;
      end
      else
      begin
         reset_powerdown_n <= (state_q != flash_host_pkg::ST_PDOWN);
         if (state_q == flash_host_pkg::ST_IDLE && req_valid && power_good && !powerdown_req)
         begin
            chip_select_n <= 1'b0;
            width_select <= req.wide;
            addr_o.block <= req.block;
            addr_o.word <= req.word;
            addr_o.half <= req.half;
            half_word_select_address_oe <= !req.wide;
            low_data_lane_o <= req.wdata[flash_host_pkg::LANE_W-1:0];
            high_data_lane_o <= req.wdata[2*flash_host_pkg::LANE_W-1:flash_host_pkg::LANE_W];
            low_data_lane_oe <= req.write;
            high_data_lane_oe <= req.write && req.wide;
         end
         else if (state_q == flash_host_pkg::ST_SETUP && cnt_zero)
         begin
            write_strobe_n <= !cur_q.write;
            output_gate_n <= cur_q.write;
         end
         else if (state_q == flash_host_pkg::ST_STROBE && cnt_zero)
         begin
            write_strobe_n <= 1'b1;
            output_gate_n <= 1'b1;
         end
         else if (state_q == flash_host_pkg::ST_HOLD && cnt_zero)
         begin
            chip_select_n <= 1'b1;
            low_data_lane_oe <= 1'b0;
            high_data_lane_oe <= 1'b0;
            half_word_select_address_oe <= 1'b0;
         end
      end
   end

   // User side answers and status
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data <= '0;
         flash_busy <= 1'b0;
         flash_active <= 1'b0;
      end
      else
      begin
         req_ready <= (state_q == flash_host_pkg::ST_IDLE) && !req_valid && power_good && !powerdown_req;
         rsp_valid <= (state_q == flash_host_pkg::ST_DONE);
         flash_active <= (state_q != flash_host_pkg::ST_PDOWN) && (state_q != flash_host_pkg::ST_RECOVER);
         flash_busy <= (state_q != flash_host_pkg::ST_PDOWN) && !rb_s;
         if (state_q == flash_host_pkg::ST_STROBE && cnt_zero && !cur_q.write)
         begin
            // Data sampled after ACCESS_CYC strobe cycles, which cover the access time with no extra allowance for the sync delay
            rsp_data[flash_host_pkg::LANE_W-1:0] <= low_s;
            rsp_data[2*flash_host_pkg::LANE_W-1:flash_host_pkg::LANE_W] <= cur_q.wide ? high_s : '0;
         end
      end
   end
endmodule

// *** logic/flash_host_pkg.sv ***
/*
 * Package for the parallel flash host controller: pin widths, bus timing
 * counts, user request and pin address structs and state encoding.
 * Assumes a 200 MHz mclk and an asynchronous flash on the far side.
 */
package flash_host_pkg;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int RECOVERY_NS = 430;
   localparam int RECOVERY_CYC = (RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ACCESS_NS = 80;
   localparam int ACCESS_CYC = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int STROBE_NS = 50;
   localparam int STROBE_CYC = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SETUP_CYC = 2;
   localparam int HOLD_CYC = 2;
   localparam int POWERDOWN_NS = 100;
   localparam int POWERDOWN_CYC = (POWERDOWN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 8;
   localparam int WORD_ADDR_W = 13;
   localparam int BLOCK_ADDR_W = 5;
   localparam int LANE_W = 8;

   typedef struct packed {
      logic write;
      logic wide;
      logic [BLOCK_ADDR_W-1:0] block;
      logic [WORD_ADDR_W-1:0] word;
      logic half;
      logic [2*LANE_W-1:0] wdata;
   } req_t;

   typedef struct packed {
      logic [BLOCK_ADDR_W-1:0] block;
      logic [WORD_ADDR_W-1:0] word;
      logic half;
   } addr_t;

   typedef enum logic [6:0] {
      ST_PDOWN = 7'h01,
      ST_RECOVER = 7'h02,
      ST_IDLE = 7'h04,
      ST_SETUP = 7'h08,
      ST_STROBE = 7'h10,
      ST_HOLD = 7'h20,
      ST_DONE = 7'h40
   } state_t;
endpackage

// *** logic/pin_sync.sv ***
/*
 * Three-stage synchroniser for an asynchronous pin; a new level is accepted
 * only when the second and third stages agree.
 * Assumes one clock domain and a synchronous active-low reset.
 */
`timescale 1ns/10ps
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
         level <= INIT;
      end
      else
      begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < WIDTH; i++)
         begin
            if (s2_q[i] == s3_q[i])
            begin
               level[i] <= s3_q[i];
            end
         end
      end
   end
endmodule

// *** tb/flash_host_bench.sv ***
/*
 * Self-checking bench: flash_host against the behavioural flash model.
 * Assumes the checker and the model are compiled first.
 */
`timescale 1ns/10ps
module flash_host_bench;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic power_good = 1'b0;
   logic powerdown_req = 1'b0;
   logic req_valid = 1'b0;
   logic tog = 1'b0;
   flash_host_pkg::req_t req = '0;
   logic req_ready, rsp_valid, flash_busy, flash_active, half_word_select_address_oe, low_data_lane_oe;
   logic high_data_lane_oe, chip_select_n, output_gate_n, write_strobe_n, width_select, reset_powerdown_n;
   logic ready_busy_n, lo_oe, hi_oe, busy_pull;
   logic [15:0] rsp_data, dq, dq_o;
   logic [7:0] low_data_lane_o, high_data_lane_o;
   flash_host_pkg::addr_t addr_o, fa;
   logic [15:0] shadow [int];
   int err_count = 0;
   int checked = 0;
   int cyc = 0;
   always #2.5 mclk = ~mclk;
   always @(posedge mclk) tog <= ~tog;
   // Released lines toggle so a stale value never passes
   assign fa = {addr_o.block, addr_o.word, half_word_select_address_oe ? addr_o.half : tog};
   assign dq[7:0] = low_data_lane_oe ? low_data_lane_o : lo_oe ? dq_o[7:0] : {8{tog}};
   assign dq[15:8] = high_data_lane_oe ? high_data_lane_o : hi_oe ? dq_o[15:8] : {8{~tog}};
   assign ready_busy_n = !busy_pull;
   flash_host #(.RECOVERY_CYC(86)) dut (.mclk, .nrst, .power_good, .powerdown_req, .req_valid, .req, .req_ready,
      .rsp_valid, .rsp_data, .flash_busy, .flash_active, .addr_o, .half_word_select_address_oe, .low_data_lane_o,
      .high_data_lane_o, .low_data_lane_oe, .high_data_lane_oe, .low_data_lane_i(dq[7:0]),
      .high_data_lane_i(dq[15:8]), .chip_select_n, .output_gate_n, .write_strobe_n, .width_select,
      .reset_powerdown_n, .ready_busy_n);
   flash_model fm (.mclk, .cs_n(chip_select_n), .oe_n(output_gate_n), .we_n(write_strobe_n), .ws(width_select),
      .rp_n(reset_powerdown_n), .addr(fa), .dq_i(dq), .dq_o, .lo_oe, .hi_oe, .busy_pull);
   task automatic check(string name, logic [15:0] exp, logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   function automatic logic [15:0] pick(logic wd, logic h, logic [15:0] v);
      return wd ? v : {8'h00, h ? v[15:8] : v[7:0]};
   endfunction
   task automatic wait_active();
      int n = 0;
      while (flash_active !== 1'b1 && n < 300)
      begin
         @(posedge mclk);
         n++;
      end
      check("flash_active", 16'h1, 16'(flash_active));
      check("req_ready", 16'h1, 16'(req_ready));
   endtask
   task automatic op(logic w, logic wd, logic [4:0] b, logic [12:0] a, logic h, logic [15:0] d);
      int n = 0;
      int k = int'({b, a});
      logic [15:0] v;
      v = shadow.exists(k) ? shadow[k] : 16'hffff;
      req <= {w, wd, b, a, h, d};
      req_valid <= 1'b1;
      @(posedge mclk);
      req_valid <= 1'b0;
      while (rsp_valid !== 1'b1 && n < 60)
      begin
         @(posedge mclk);
         n++;
      end
      check("rsp_valid", 16'h1, 16'(rsp_valid));
      if (w)
         shadow[k] = wd ? d : h ? {d[7:0], v[7:0]} : {v[15:8], d[7:0]};
      else
         check("rsp_data", pick(wd, h, v), rsp_data);
   endtask
   task automatic rand_ops(int cnt);
      for (int i = 0; i < cnt; i++)
         op(1'($urandom), 1'($urandom), 5'($urandom_range(0, 1) * 31),
            $urandom_range(0, 1) ? 13'h1fff : 13'($urandom_range(0, 2)), 1'($urandom), 16'($urandom));
   endtask
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         finish_test();
      end
   end
   initial
   begin
      void'($urandom(32'hbd24));
      repeat (10) @(posedge mclk);
      nrst <= 1'b1;
      power_good <= 1'b1;
      wait_active();
      op(1'b1, 1'b1, 5'h1f, 13'h1fff, 1'b0, 16'hbeef);
      repeat (6) @(posedge mclk);
      check("flash_busy", 16'h1, 16'(flash_busy));
      repeat (10) @(posedge mclk);
      check("flash_busy", 16'h0, 16'(flash_busy));
      rand_ops(80);
      op(1'b1, 1'b0, 5'h00, 13'h0000, 1'b1, 16'h005a);
      powerdown_req <= 1'b1;
      repeat (30) @(posedge mclk);
      check("reset_powerdown_n", 16'h0, 16'(reset_powerdown_n));
      check("flash_busy", 16'h0, 16'(flash_busy));
      powerdown_req <= 1'b0;
      wait_active();
      op(1'b0, 1'b1, 5'h1f, 13'h1fff, 1'b0, 16'h0000);
      rand_ops(30);
      power_good <= 1'b0;
      repeat (20) @(posedge mclk);
      check("reset_powerdown_n", 16'h0, 16'(reset_powerdown_n));
      power_good <= 1'b1;
      wait_active();
      rand_ops(10);
      finish_test();
   end
endmodule
bind flash_host flash_host_sva #(.RECOVERY_CYC(RECOVERY_CYC)) chk (.mclk, .nrst, .power_good, .chip_select_n,
   .output_gate_n, .write_strobe_n, .width_select, .reset_powerdown_n, .half_word_select_address_oe,
   .low_data_lane_oe, .high_data_lane_oe, .addr_o);

// *** tb/flash_host_sva.sv ***
/*
 * Pin protocol assertions for the flash host controller.
 * Assumes binding onto flash_host, one clock and synchronous reset.
 */
`timescale 1ns/10ps
module flash_host_sva #(
   parameter int RECOVERY_CYC = 86
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic power_good,
   input wire logic chip_select_n,
   input wire logic output_gate_n,
   input wire logic write_strobe_n,
   input wire logic width_select,
   input wire logic reset_powerdown_n,
   input wire logic half_word_select_address_oe,
   input wire logic low_data_lane_oe,
   input wire logic high_data_lane_oe,
   input wire flash_host_pkg::addr_t addr_o
);
   logic [7:0] rec_q;
   // Cycles since the flash left power-down
   always_ff @(posedge mclk)
   begin
      if (!nrst || !reset_powerdown_n)
         rec_q <= 8'h00;
      else if (rec_q != 8'hff)
         rec_q <= rec_q + 8'h01;
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   sequence s_wr;
      !write_strobe_n;
   endsequence
   sequence s_wr_x16;
      s_wr ##0 width_select;
   endsequence
   a_gate_in_write: assert property (s_wr |-> output_gate_n)
      else $error("output gate low in write");
   a_cs_held: assert property ((!write_strobe_n || !output_gate_n) |-> !chip_select_n)
      else $error("strobe without chip select");
   a_addr_stable: assert property (s_wr |=> $stable(addr_o))
      else $error("address moved in write");
   a_low_lane_write: assert property (s_wr |-> low_data_lane_oe)
      else $error("low lane not driven in write");
   a_x16_high_lane: assert property (s_wr_x16 |-> high_data_lane_oe)
      else $error("high lane not driven in x16 write");
   a_half_x8_only: assert property (half_word_select_address_oe |-> !width_select)
      else $error("half select driven in x16");
   a_no_contention: assert property (!output_gate_n |-> !low_data_lane_oe && !high_data_lane_oe)
      else $error("host drives lanes in read");
   a_recovery_wait: assert property ($fell(chip_select_n) |-> rec_q >= RECOVERY_CYC)
      else $error("access inside recovery time");
   a_pgood_pdown: assert property ((!power_good)[*8] |-> !reset_powerdown_n)
      else $error("flash powered without good supply");
endmodule

// *** tb/flash_model.sv ***
/*
 * Behavioural flash device: array memory, x8/x16 lanes, busy pin.
 * Assumes the bench resolves shared lanes and the open-drain busy pin.
 */
`timescale 1ns/10ps
module flash_model (
   input wire logic mclk,
   input wire logic cs_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic ws,
   input wire logic rp_n,
   input wire flash_host_pkg::addr_t addr,
   input wire logic [15:0] dq_i,
   output logic [15:0] dq_o,
   output logic lo_oe,
   output logic hi_oe,
   output logic busy_pull
);
   logic [15:0] mem [int];
   logic [15:0] q = 16'hffff;
   logic [15:0] w;
   logic we_q = 1'b1;
   logic [3:0] busy_q = 4'h0;
   int k;
   function automatic logic [15:0] rd(int a);
      return mem.exists(a) ? mem[a] : 16'hffff;
   endfunction
   assign k = int'({addr.block, addr.word});
   always @(posedge mclk) q <= rd(k);
   // Array reads only: the mode left after power-down
   assign dq_o = {q[15:8], (ws || !addr.half) ? q[7:0] : q[15:8]};
   assign lo_oe = rp_n && !cs_n && !oe_n;
   assign hi_oe = lo_oe && ws;
   assign busy_pull = busy_q != 4'h0;
   always @(posedge we_n)
   begin
      if (!cs_n && rp_n)
      begin
         w = rd(k);
         if (ws)
            w = dq_i;
         else if (addr.half)
            w[15:8] = dq_i[7:0];
         else
            w[7:0] = dq_i[7:0];
         mem[k] = w;
      end
   end
   always_ff @(posedge mclk)
   begin
      we_q <= we_n;
      if (!rp_n)
         busy_q <= 4'h0;
      else if (we_n && !we_q && !cs_n)
         busy_q <= 4'hc;
      else if (busy_q != 4'h0)
         busy_q <= busy_q - 4'h1;
   end
endmodule
